// [hw/gpcd_defines.vh]
// register map, field positions and reset values for the port c/d block
// assumes a byte-wide register port with an 8-bit word address
`ifndef GPCD_DEFINES_VH
`define GPCD_DEFINES_VH

`define GPCD_A_C_PIN      8'h00
`define GPCD_A_C_LAT      8'h01
`define GPCD_A_C_DIR      8'h02
`define GPCD_A_D_PIN      8'h03
`define GPCD_A_D_LAT      8'h04
`define GPCD_A_D_DIR      8'h05
`define GPCD_A_MEM_CTRL   8'h06
`define GPCD_A_PAR_CTRL   8'h07

`define GPCD_DIR_RST      8'hFF
`define GPCD_LAT_RST      8'h00
`define GPCD_ZERO8        8'h00
`define GPCD_ONES8        8'hFF

`define GPCD_BUSDIS_BIT   7
`define GPCD_PARMODE_BIT  4
`define GPCD_MEM_RST      8'h80
`define GPCD_PAR_RST      8'h00
`define GPCD_MEM_MASK     8'h80
`define GPCD_PAR_MASK     8'h10

`define GPCD_B_OSC_OUT    0
`define GPCD_B_OSC_IN     1
`define GPCD_B_CAP1       2
`define GPCD_B_SCK        3
`define GPCD_B_SDA        4
`define GPCD_B_SDO        5
`define GPCD_B_TX         6
`define GPCD_B_DT         7

`endif

// [hw/gpcd_ports.v]
// ports c and d with peripheral pin takeover and register access
// assumes a same-clock register port, pins reaching it through pads
`timescale 1ns/100ps
`include "gpcd_defines.vh"

module gpcd_ports (
	input  wire       clk,          // 40 mhz system clock
	input  wire       resetn,       // async reset, active low
	input  wire [7:0] addr,         // register address
	input  wire [7:0] wdata,        // write data
	input  wire       wr,           // write strobe
	input  wire       rd,           // read strobe
	output reg  [7:0] rdata,        // read data, cycle after rd
	input  wire       big_package,  // memory bus bonded out
	input  wire       cap2_pin_sel, // capture unit two pin select
	input  wire       tosc_en,      // timer oscillator enabled
	input  wire       cap1_out_en,  // capture unit one drive active
	input  wire       cap1_out,     // capture unit one output
	input  wire       cap2_out_en,  // capture unit two drive active
	input  wire       cap2_out,     // capture unit two output
	input  wire       ssp_en,       // sync serial module enabled
	input  wire       ssp_i2c,      // sync serial module in i2c mode
	input  wire       ssp_sck_out,  // serial clock out
	input  wire       ssp_sda_oe,   // i2c data drive (drives low)
	input  wire       ssp_sdo,      // spi data out
	input  wire       eus_en,       // enhanced serial unit enabled
	input  wire       eus_sync,     // enhanced serial in synchronous mode
	input  wire       eus_tx,       // transmit data out
	input  wire       eus_dt_oe,    // sync data line drive enable
	input  wire       eus_dt,       // sync data out
	input  wire [7:0] ebus_ad_out,  // memory bus address/data out
	input  wire       ebus_ad_oe,   // memory bus drive enable
	input  wire [7:0] par_out,      // parallel port read data
	input  wire       par_oe,       // parallel port drive enable
	input  wire [7:0] pc_in,        // port c pad levels
	output reg  [7:0] pc_out,       // port c pad drive value
	output reg  [7:0] pc_oe,        // port c pad drive enable
	input  wire [7:0] pd_in,        // port d pad levels
	output reg  [7:0] pd_out,       // port d pad drive value
	output reg  [7:0] pd_oe,        // port d pad drive enable
	output reg        cap1_in,      // capture unit one input
	output reg        cap2_in,      // capture unit two input
	output reg        cnt_ext_in,   // shared counter input
	output reg        ssp_sck_in,   // serial clock in
	output reg        ssp_sdi,      // spi/i2c data in
	output reg        eus_rx,       // receive / sync data in
	output reg        eus_ck_in,    // sync clock in
	output reg  [7:0] ebus_ad_in,   // memory bus data in
	output reg  [7:0] par_in        // parallel port write data
);

	// software visible registers and their next values
	reg  [7:0] pc_lat_r;
	reg  [7:0] pc_lat_nxt;
	reg  [7:0] pc_dir_r;
	reg  [7:0] pc_dir_nxt;
	reg  [7:0] pd_lat_r;
	reg  [7:0] pd_lat_nxt;
	reg  [7:0] pd_dir_r;
	reg  [7:0] pd_dir_nxt;
	reg  [7:0] mem_ctrl_r;
	reg  [7:0] mem_ctrl_nxt;
	reg  [7:0] par_ctrl_r;
	reg  [7:0] par_ctrl_nxt;

	// pad synchronisers
	reg  [7:0] pc_s1_r;
	reg  [7:0] pc_s2_r;
	reg  [7:0] pd_s1_r;
	reg  [7:0] pd_s2_r;

	// next values of the registered outputs
	reg  [7:0] rdata_nxt;
	reg  [7:0] pc_out_nxt;
	reg  [7:0] pc_oe_nxt;
	reg  [7:0] pd_out_nxt;
	reg  [7:0] pd_oe_nxt;
	reg        cap1_in_nxt;
	reg        cap2_in_nxt;
	reg        cnt_ext_in_nxt;
	reg        ssp_sck_in_nxt;
	reg        ssp_sdi_nxt;
	reg        eus_rx_nxt;
	reg        eus_ck_in_nxt;
	reg  [7:0] ebus_ad_in_nxt;
	reg  [7:0] par_in_nxt;

	// write selects, one per register
	wire       we_pc_lat;
	wire       we_pc_dir;
	wire       we_pd_lat;
	wire       we_pd_dir;
	wire       we_mem;
	wire       we_par;

	// who owns the pins this cycle
	wire       ebus_on;
	wire       par_on;
	wire       i2c_on;
	wire       spi_on;
	wire       eus_async;
	wire       eus_synced;

	// plain port behaviour: drive latch where direction is zero
	function [7:0] gpcd_oe;
		input [7:0] dir;
		begin
			gpcd_oe = ~dir;
		end
	endfunction

	// a port d takeover drives all eight pins together or none
	function [7:0] gpcd_all;
		input en;
		begin
			gpcd_all = en ? `GPCD_ONES8 : `GPCD_ZERO8;
		end
	endfunction

	// strobe qualified address match
	function gpcd_hit;
		input       stb;
		input [7:0] a;
		input [7:0] reg_a;
		begin
			gpcd_hit = stb && (a == reg_a);
		end
	endfunction

	// a peripheral input only sees its pin while the pin is an input
	function gpcd_in;
		input dir_bit;
		input pin_bit;
		begin
			gpcd_in = dir_bit & pin_bit;
		end
	endfunction

	// pads are asynchronous to clk, so two stages before any use
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_s1_r <= `GPCD_ZERO8;
			pc_s2_r <= `GPCD_ZERO8;
			pd_s1_r <= `GPCD_ZERO8;
			pd_s2_r <= `GPCD_ZERO8;
		end else begin
			pc_s1_r <= pc_in;
			pc_s2_r <= pc_s1_r;
			pd_s1_r <= pd_in;
			pd_s2_r <= pd_s1_r;
		end
	end

	// pin address writes land in the latch, so both decode to it
	assign we_pc_lat = gpcd_hit(wr, addr, `GPCD_A_C_PIN) |
		gpcd_hit(wr, addr, `GPCD_A_C_LAT);
	assign we_pc_dir = gpcd_hit(wr, addr, `GPCD_A_C_DIR);
	assign we_pd_lat = gpcd_hit(wr, addr, `GPCD_A_D_PIN) |
		gpcd_hit(wr, addr, `GPCD_A_D_LAT);
	assign we_pd_dir = gpcd_hit(wr, addr, `GPCD_A_D_DIR);
	assign we_mem    = gpcd_hit(wr, addr, `GPCD_A_MEM_CTRL);
	assign we_par    = gpcd_hit(wr, addr, `GPCD_A_PAR_CTRL);

	assign ebus_on    = big_package & ~mem_ctrl_r[`GPCD_BUSDIS_BIT];
	assign par_on     = par_ctrl_r[`GPCD_PARMODE_BIT];
	assign i2c_on     = ssp_en & ssp_i2c;
	assign spi_on     = ssp_en & ~ssp_i2c;
	assign eus_async  = eus_en & ~eus_sync;
	assign eus_synced = eus_en & eus_sync;

	// register next values; unused control bits stay zero
	always @* begin
		pc_lat_nxt   = pc_lat_r;
		pc_dir_nxt   = pc_dir_r;
		pd_lat_nxt   = pd_lat_r;
		pd_dir_nxt   = pd_dir_r;
		mem_ctrl_nxt = mem_ctrl_r;
		par_ctrl_nxt = par_ctrl_r;
		if (we_pc_lat) begin
			pc_lat_nxt = wdata;
		end
		if (we_pc_dir) begin
			pc_dir_nxt = wdata;
		end
		if (we_pd_lat) begin
			pd_lat_nxt = wdata;
		end
		if (we_pd_dir) begin
			pd_dir_nxt = wdata;
		end
		if (we_mem) begin
			mem_ctrl_nxt = wdata & `GPCD_MEM_MASK;
		end
		if (we_par) begin
			par_ctrl_nxt = wdata & `GPCD_PAR_MASK;
		end
	end

	// bus disabled at reset so port d pins come up as inputs
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_lat_r   <= `GPCD_LAT_RST;
			pd_lat_r   <= `GPCD_LAT_RST;
			pc_dir_r   <= `GPCD_DIR_RST;
			pd_dir_r   <= `GPCD_DIR_RST;
			mem_ctrl_r <= `GPCD_MEM_RST;
			par_ctrl_r <= `GPCD_PAR_RST;
		end else begin
			pc_lat_r   <= pc_lat_nxt;
			pd_lat_r   <= pd_lat_nxt;
			pc_dir_r   <= pc_dir_nxt;
			pd_dir_r   <= pd_dir_nxt;
			mem_ctrl_r <= mem_ctrl_nxt;
			par_ctrl_r <= par_ctrl_nxt;
		end
	end

	// read mux; direction reads never see peripheral overrides
	always @* begin
		rdata_nxt = `GPCD_ZERO8;
		if (rd) begin
			case (addr)
			`GPCD_A_C_PIN:    rdata_nxt = pc_s2_r;
			`GPCD_A_C_LAT:    rdata_nxt = pc_lat_r;
			`GPCD_A_C_DIR:    rdata_nxt = pc_dir_r;
			`GPCD_A_D_PIN:    rdata_nxt = pd_s2_r;
			`GPCD_A_D_LAT:    rdata_nxt = pd_lat_r;
			`GPCD_A_D_DIR:    rdata_nxt = pd_dir_r;
			`GPCD_A_MEM_CTRL: rdata_nxt = mem_ctrl_r;
			`GPCD_A_PAR_CTRL: rdata_nxt = par_ctrl_r;
			default:          rdata_nxt = `GPCD_ZERO8;
			endcase
		end
	end

	// port c pin mux; later assignments win over earlier ones
	always @* begin
		pc_out_nxt = pc_lat_r;
		pc_oe_nxt  = gpcd_oe(pc_dir_r);
		if (cap1_out_en && !pc_dir_r[`GPCD_B_CAP1]) begin
			pc_out_nxt[`GPCD_B_CAP1] = cap1_out;
		end
		if (cap2_pin_sel && cap2_out_en &&
			!pc_dir_r[`GPCD_B_OSC_IN]) begin
			pc_out_nxt[`GPCD_B_OSC_IN] = cap2_out;
		end
		if (ssp_en && !pc_dir_r[`GPCD_B_SCK]) begin
			pc_out_nxt[`GPCD_B_SCK] = ssp_sck_out;
		end
		if (spi_on && !pc_dir_r[`GPCD_B_SDO]) begin
			pc_out_nxt[`GPCD_B_SDO] = ssp_sdo;
		end
		if (i2c_on) begin
			// open-drain data: drive low only while asserting
			pc_out_nxt[`GPCD_B_SDA] = 1'b0;
			pc_oe_nxt[`GPCD_B_SDA]  = ssp_sda_oe;
		end
		if (eus_async) begin
			pc_out_nxt[`GPCD_B_TX] = eus_tx;
			pc_oe_nxt[`GPCD_B_TX]  = 1'b1;
		end
		if (eus_synced) begin
			pc_out_nxt[`GPCD_B_DT] = eus_dt;
			pc_oe_nxt[`GPCD_B_DT]  = eus_dt_oe;
		end
		// oscillator pins are analogue, nothing digital may drive them
		if (tosc_en) begin
			pc_out_nxt[`GPCD_B_OSC_OUT] = 1'b0;
			pc_oe_nxt[`GPCD_B_OSC_OUT]  = 1'b0;
			pc_out_nxt[`GPCD_B_OSC_IN]  = 1'b0;
			pc_oe_nxt[`GPCD_B_OSC_IN]   = 1'b0;
		end
	end

	// port d: memory bus over parallel port over plain i/o
	always @* begin
		pd_out_nxt = pd_lat_r;
		pd_oe_nxt  = gpcd_oe(pd_dir_r);
		if (ebus_on) begin
			pd_out_nxt = ebus_ad_out;
			pd_oe_nxt  = gpcd_all(ebus_ad_oe);
		end else if (par_on) begin
			pd_out_nxt = par_out;
			pd_oe_nxt  = gpcd_all(par_oe);
		end
	end

	// peripheral inputs from synced pins; zero when not routed, except ssp_sdi and eus_rx, which always follow their pins
	always @* begin
		cap1_in_nxt    = gpcd_in(pc_dir_r[`GPCD_B_CAP1],
			pc_s2_r[`GPCD_B_CAP1]);
		cap2_in_nxt    = cap2_pin_sel & ~tosc_en &
			gpcd_in(pc_dir_r[`GPCD_B_OSC_IN],
			pc_s2_r[`GPCD_B_OSC_IN]);
		cnt_ext_in_nxt = ~tosc_en &
			gpcd_in(pc_dir_r[`GPCD_B_OSC_OUT],
			pc_s2_r[`GPCD_B_OSC_OUT]);
		ssp_sck_in_nxt = gpcd_in(pc_dir_r[`GPCD_B_SCK],
			pc_s2_r[`GPCD_B_SCK]);
		ssp_sdi_nxt    = pc_s2_r[`GPCD_B_SDA];
		eus_rx_nxt     = pc_s2_r[`GPCD_B_DT];
		eus_ck_in_nxt  = eus_sync & pc_s2_r[`GPCD_B_TX];
		ebus_ad_in_nxt = `GPCD_ZERO8;
		par_in_nxt     = `GPCD_ZERO8;
		if (ebus_on) begin
			ebus_ad_in_nxt = pd_s2_r;
		end else if (par_on) begin
			par_in_nxt = pd_s2_r;
		end
	end

	// every output straight from a flop; reset leaves all pins input
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata      <= `GPCD_ZERO8;
			pc_out     <= `GPCD_ZERO8;
			pc_oe      <= `GPCD_ZERO8;
			pd_out     <= `GPCD_ZERO8;
			pd_oe      <= `GPCD_ZERO8;
			cap1_in    <= 1'b0;
			cap2_in    <= 1'b0;
			cnt_ext_in <= 1'b0;
			ssp_sck_in <= 1'b0;
			ssp_sdi    <= 1'b0;
			eus_rx     <= 1'b0;
			eus_ck_in  <= 1'b0;
			ebus_ad_in <= `GPCD_ZERO8;
			par_in     <= `GPCD_ZERO8;
		end else begin
			rdata      <= rdata_nxt;
			pc_out     <= pc_out_nxt;
			pc_oe      <= pc_oe_nxt;
			pd_out     <= pd_out_nxt;
			pd_oe      <= pd_oe_nxt;
			cap1_in    <= cap1_in_nxt;
			cap2_in    <= cap2_in_nxt;
			cnt_ext_in <= cnt_ext_in_nxt;
			ssp_sck_in <= ssp_sck_in_nxt;
			ssp_sdi    <= ssp_sdi_nxt;
			eus_rx     <= eus_rx_nxt;
			eus_ck_in  <= eus_ck_in_nxt;
			ebus_ad_in <= ebus_ad_in_nxt;
			par_in     <= par_in_nxt;
		end
	end

endmodule

// [tb/gpcd_chk_assertions.sv]
// timing checks for the port c/d block
// shadows the port d registers from bus writes; offsets as in the map
`timescale 1ns/100ps
module gpcd_chk (
	input wire       clk,         // clock
	input wire       resetn,      // reset
	input wire [7:0] addr,        // address
	input wire [7:0] wdata,       // write data
	input wire       wr,          // write
	input wire       rd,          // read
	input wire [7:0] rdata,       // read data
	input wire       big_package, // bus bonded
	input wire       tosc_en,     // oscillator on
	input wire       ebus_ad_oe,  // bus drive
	input wire       par_oe,      // parallel drive
	input wire [7:0] pc_oe,       // c enable
	input wire [7:0] pd_oe,       // d enable
	input wire [7:0] pd_out       // d drive
);
	reg [7:0] dir_r, lat_r;
	reg       bdis_r, par_r;
	wire      bus_on = big_package & ~bdis_r;
	wire      par_on = ~bus_on & par_r;
	wire      gp_on  = ~bus_on & ~par_r;
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dir_r  <= 8'hFF;
			lat_r  <= 8'h00;
			bdis_r <= 1'b1;
			par_r  <= 1'b0;
		end else if (wr) begin
			if (addr == 8'h05) dir_r <= wdata;
			if (addr == 8'h03 || addr == 8'h04) lat_r <= wdata;
			if (addr == 8'h06) bdis_r <= wdata[7];
			if (addr == 8'h07) par_r <= wdata[4];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_rdata_idle: assert property (
		!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
	a_lat_read: assert property (
		wr && addr == 8'h04 ##1 rd && addr == 8'h04 |=>
		rdata == $past(wdata, 2)) else $error("latch readback");
	a_dir_read: assert property (
		wr && addr == 8'h02 ##1 rd && addr == 8'h02 |=>
		rdata == $past(wdata, 2)) else $error("dir readback");
	a_reset_input: assert property (
		$rose(resetn) |-> pc_oe == 8'h00 && pd_oe == 8'h00)
		else $error("pins not input after reset");
	a_port_dir: assert property (
		$past(gp_on) |-> pd_oe == ~$past(dir_r) &&
		(pd_out & pd_oe) == ($past(lat_r) & pd_oe))
		else $error("port d dir/latch");
	a_bus_take: assert property (
		$past(bus_on) |-> pd_oe == {8{$past(ebus_ad_oe)}})
		else $error("memory bus takeover");
	a_par_take: assert property (
		$past(par_on) |-> pd_oe == {8{$past(par_oe)}})
		else $error("parallel takeover");
	a_osc_input: assert property (
		$past(tosc_en) |-> pc_oe[1:0] == 2'b00)
		else $error("oscillator pins driven");
endmodule

// [tb/gpcd_pads.sv]
// pad model for ports c and d
// a pin shows its own driver when enabled, else the outside level
`timescale 1ns/100ps
module gpcd_pads (
	input  wire [7:0] pc_out, // c drive
	input  wire [7:0] pc_oe,  // c enable
	input  wire [7:0] pd_out, // d drive
	input  wire [7:0] pd_oe,  // d enable
	input  wire [7:0] ext_c,  // outside level c
	input  wire [7:0] ext_d,  // outside level d
	output wire [7:0] pc_in,  // c pad level
	output wire [7:0] pd_in   // d pad level
);
	assign pc_in = (pc_out & pc_oe) | (ext_c & ~pc_oe);
	assign pd_in = (pd_out & pd_oe) | (ext_d & ~pd_oe);
endmodule

// [tb/tb.sv]
// self-checking bench for the port c/d block
// drives the register port and peripheral levels; pads from gpcd_pads
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
	failures++; $display("unexpected t=%0t got %h exp %h", $time, a, e); \
	end end
module tb;
	reg        clk, resetn, wr, rd, big_package;
	reg  [7:0] addr, wdata, par_out, ebus_ad_out, ext_c, ext_d, lat, dir;
	reg        cap2_pin_sel, tosc_en, cap1_out_en, cap1_out, cap2_out_en;
	reg        cap2_out, ssp_en, ssp_i2c, ssp_sck_out, ssp_sda_oe, ssp_sdo;
	reg [15:0] exp16;
	reg        eus_en, eus_sync, eus_tx, eus_dt_oe, eus_dt, ebus_ad_oe;
	reg        par_oe;
	reg [31:0] seed;
	wire [7:0] rdata, pc_in, pc_out, pc_oe, pd_in, pd_out, pd_oe;
	wire [7:0] ebus_ad_in, par_in;
	wire       cap1_in, cap2_in, cnt_ext_in, ssp_sck_in;
	wire       ssp_sdi, eus_rx, eus_ck_in;
	int        failures, samples_checked, i;
	gpcd_ports dut_u (.*);
	gpcd_pads  pad_u (.*);
	function [31:0] xs(input [31:0] s);
		xs = s ^ (s << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	function [7:0] pin_exp(input [7:0] l, d, e);
		pin_exp = (l & ~d) | (e & d);
	endfunction
	// expected port c {enable, driven value} from latch and direction
	function [15:0] c_drv(input [7:0] l, d);
		reg [7:0] o, e;
		o = l;
		e = ~d;
		if (cap1_out_en && !d[2]) o[2] = cap1_out;
		if (cap2_pin_sel && cap2_out_en && !d[1]) o[1] = cap2_out;
		if (ssp_en && !d[3]) o[3] = ssp_sck_out;
		if (ssp_en && !ssp_i2c && !d[5]) o[5] = ssp_sdo;
		if (ssp_en && ssp_i2c) begin
			o[4] = 1'b0;
			e[4] = ssp_sda_oe;
		end
		if (eus_en && !eus_sync) begin
			o[6] = eus_tx;
			e[6] = 1'b1;
		end
		if (eus_en && eus_sync) begin
			o[7] = eus_dt;
			e[7] = eus_dt_oe;
		end
		if (tosc_en) begin
			o[1:0] = 2'b00;
			e[1:0] = 2'b00;
		end
		c_drv = {e, o & e};
	endfunction
	task w(input [7:0] a, d);
		addr <= a; wdata <= d; wr <= 1; rd <= 0;
		@(posedge clk);
	endtask
	task r(input [7:0] a, e);
		addr <= a; rd <= 1; wr <= 0;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		`CHK(rdata, e)
		@(posedge clk);
	endtask
	task idle(input int n);
		wr <= 0; rd <= 0;
		repeat (n) @(posedge clk);
	endtask
	task stop_test;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25 * 20000);
		failures++;
		stop_test;
	end
	initial begin
		{resetn, wr, rd, big_package, addr, wdata, par_out} = 0;
		{ebus_ad_out, ext_c, ext_d, cap2_pin_sel, tosc_en, cap1_out_en} = 0;
		{cap1_out, cap2_out_en, cap2_out, ssp_en, ssp_i2c, ssp_sck_out} = 0;
		{ssp_sda_oe, ssp_sdo, eus_en, eus_sync, eus_tx, eus_dt_oe} = 0;
		{eus_dt, ebus_ad_oe, par_oe, failures, samples_checked} = 0;
		seed = 32'h49e8_b23d;
		repeat (4) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		r(8'h02, 8'hFF);
		r(8'h05, 8'hFF);
		r(8'h20, 8'h00);
		$display("test reset done");
		for (i = 0; i < 40; i++) begin
			seed = xs(seed);
			{cap2_pin_sel, tosc_en, cap1_out_en, cap1_out, cap2_out_en, cap2_out,
			 ssp_en, ssp_i2c, ssp_sck_out, ssp_sda_oe, ssp_sdo, eus_en,
			 eus_sync, eus_tx, eus_dt_oe, eus_dt, ebus_ad_oe, par_oe}
				<= seed[17:0];
			{ext_c, ext_d} <= seed[31:16];
			seed = xs(seed);
			lat = seed[7:0];
			dir = seed[15:8];
			w(8'h01, lat);
			w(8'h02, dir);
			r(8'h02, dir);
			r(8'h01, lat);
			w(8'h05, dir);
			w(8'h03, ~lat);
			idle(6);
			@(negedge clk);
			exp16 = c_drv(lat, dir);
			`CHK(pc_oe, exp16[15:8])
			`CHK(pc_out & pc_oe, exp16[7:0])
			`CHK(cnt_ext_in, ~tosc_en & dir[0] & ext_c[0])
			`CHK(cap1_in, dir[2] & ext_c[2])
			@(posedge clk);
			r(8'h03, pin_exp(~lat, dir, ext_d));
			r(8'h04, ~lat);
			w(8'h04, lat);
			r(8'h04, lat);
		end
		$display("test random ports done");
		ebus_ad_out <= seed[7:0];
		par_out <= seed[15:8];
		big_package <= 1;
		ebus_ad_oe <= 1;
		par_oe <= 1;
		w(8'h06, 8'h00);
		idle(4);
		@(negedge clk);
		`CHK(pd_out, ebus_ad_out)
		`CHK(pd_oe, 8'hFF)
		@(posedge clk);
		ebus_ad_oe <= 0;
		idle(6);
		@(negedge clk);
		`CHK(ebus_ad_in, ext_d)
		@(posedge clk);
		w(8'h06, 8'h80);
		w(8'h07, 8'h10);
		idle(4);
		@(negedge clk);
		`CHK(pd_out, par_out)
		`CHK(pd_oe, 8'hFF)
		@(posedge clk);
		par_oe <= 0;
		idle(6);
		@(negedge clk);
		`CHK(par_in, ext_d)
		@(posedge clk);
		r(8'h07, 8'h10);
		r(8'h06, 8'h80);
		w(8'h07, 8'h00);
		idle(2);
		$display("test takeover done");
		stop_test;
	end
endmodule
bind gpcd_ports gpcd_chk chk_u (.*);
